// ===== verif/optical_sample_fifo_ctrl_tb.sv
// self-checking bench for the sample queue
`timescale 1ns/1ps
module optical_sample_fifo_ctrl_tb;
  logic           clk_sys_i;
  logic           rst_b_i;
  logic           sclk, cs_b, mosi, miso, miso_oe;
  logic           valid, last, ready, int_b, pdown;
  osf_pkg::item_s item;
  int             errors = 0;
  int             n_checks = 0;

  serial_host_model HOST (.sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));
  optical_sample_fifo_ctrl DUT (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .sample_valid_i(valid), .sample_item_i(item),
    .sample_last_i(last), .sample_ready_o(ready), .int_b_o(int_b), .power_down_o(pdown));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    HOST.frame(a, 1'b1, 1, 8'h00);
    chk(HOST.rx_q[2], exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    HOST.frame(a, 1'b0, 1, d);
  endtask

  // one item read from the data port, three bytes
  task automatic rdi(input logic [23:0] exp);
    HOST.frame(8'h08, 1'b1, 3, 8'h00);
    chk(HOST.rx_q[2], exp[23:16]);
    chk(HOST.rx_q[3], exp[15:8]);
    chk(HOST.rx_q[4], exp[7:0]);
  endtask

  // offer one item, hold it until taken, then let it land in the queue
  task automatic push(input logic [18:0] v, input logic l);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    valid <= 1'b1;
    item  <= {5'h01, v};
    last  <= l;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ready !== 1'b1 && k < 50);
    valid <= 1'b0;
    if (k >= 50) begin
      errors++;
      $display("ERROR %0t item never taken", $time);
      test_done();
    end
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic t_init;
    push(19'h00007, 1'b1);
    wr(8'h09, 8'h05);
    wr(8'h0d, 8'h01);
    repeat (25000) @(posedge clk_sys_i);
    rd(8'h07, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h0d, 8'h02);
    chk({7'h0, pdown}, 8'h01);
    wr(8'h09, 8'h00);
    wr(8'h0d, 8'h00);
    chk({7'h0, pdown}, 8'h00);
    $display("init done");
  endtask

  task automatic t_regs;
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h03, 8'h00);
    // unmapped place reads zero
    rd(8'h0e, 8'h00);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h7f);
    wr(8'h09, 8'h00);
    $display("regs done");
  endtask

  task automatic t_format;
    push(19'h5a5a5, 1'b0);
    push(19'h00001, 1'b1);
    rd(8'h07, 8'h02);
    rdi({5'h01, 19'h5a5a5});
    rd(8'h07, 8'h01);
    rdi({5'h01, 19'h00001});
    HOST.frame(8'h08, 1'b1, 3, 8'h00);
    chk({3'h0, HOST.rx_q[2][7:3]}, 8'h1e);
    rd(8'h07, 8'h00);
    rd(8'h00, 8'h40);
    rd(8'h00, 8'h00);
    $display("format done");
  endtask

  task automatic t_wmark;
    wr(8'h09, 8'h7d);
    wr(8'h03, 8'h80);
    push(19'h1, 1'b0);
    push(19'h2, 1'b0);
    chk({7'h0, int_b}, 8'h01);
    push(19'h3, 1'b0);
    chk({7'h0, int_b}, 8'h00);
    rd(8'h07, 8'h03);
    rd(8'h00, 8'h80);
    chk({7'h0, int_b}, 8'h01);
    push(19'h4, 1'b0);
    chk({7'h0, int_b}, 8'h00);
    HOST.frame(8'h08, 1'b1, 3, 8'h00);
    chk({7'h0, int_b}, 8'h00);
    wr(8'h0a, 8'h08);
    HOST.frame(8'h08, 1'b1, 3, 8'h00);
    chk({7'h0, int_b}, 8'h01);
    wr(8'h0a, 8'h04);
    push(19'h5, 1'b0);
    chk({7'h0, int_b}, 8'h00);
    rd(8'h00, 8'h80);
    push(19'h6, 1'b0);
    chk({7'h0, int_b}, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h0a, 8'h10);
    rd(8'h0a, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h00, 8'h00);
    $display("watermark done");
  endtask

  task automatic t_full;
    for (int i = 0; i < 130; i++) push(i[18:0], 1'b0);
    // tally read before count, as a host would
    rd(8'h06, 8'h02);
    rd(8'h07, 8'h80);
    rd(8'h04, 8'h00);
    rdi({5'h01, 19'h0});
    rd(8'h06, 8'h00);
    rd(8'h05, 8'h01);
    wr(8'h0a, 8'h12);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h06, 8'h00);
    for (int i = 0; i < 129; i++) push(i[18:0], 1'b0);
    rd(8'h06, 8'h01);
    rd(8'h07, 8'h80);
    rdi({5'h01, 19'h1});
    $display("full done");
  endtask

  task automatic t_tstamp;
    wr(8'h0a, 8'h30);
    for (int i = 0; i < 8; i++) push(i[18:0], 1'b1);
    rd(8'h07, 8'h09);
    HOST.frame(8'h08, 1'b1, 27, 8'h00);
    chk({3'h0, HOST.rx_q[23][7:3]}, 8'h01);
    chk({3'h0, HOST.rx_q[26][7:3]}, 8'h1f);
    wr(8'h0a, 8'h10);
    for (int i = 0; i < 8; i++) push(i[18:0], 1'b1);
    rd(8'h07, 8'h08);
    $display("timestamp done");
  endtask

  initial begin
    rst_b_i = 1'b0;
    valid = 1'b0;
    last = 1'b0;
    item = '0;
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    // two sync stages plus margin before the first request
    repeat (4) @(posedge clk_sys_i);
    t_init();
    t_regs();
    t_format();
    t_wmark();
    t_full();
    t_tstamp();
    test_done();
  end
endmodule // optical_sample_fifo_ctrl_tb

// ===== verif/serial_host_model.sv
// host processor model: serial register master, mode 0, msb first
`timescale 1ns/1ps
module serial_host_model (
  // serial pins
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // bytes seen on miso in the last frame: address, command, data...
  logic [7:0] rx_q [$];
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // link clock runs only inside frames, 320 ns period
  task automatic xbyte(input logic [7:0] tx);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      mosi_o <= tx[i];
      #160 sclk_o <= 1'b1;
      // an undriven line reads back inverted, so a missing enable shows up
      rx[i] = miso_oe_i ? miso_i : ~miso_i;
      #160 sclk_o <= 1'b0;
    end
    rx_q.push_back(rx);
  endtask
  // n data bytes per frame: multiples of three for data port reads, one for register access
  task automatic frame(input logic [7:0] a, input logic rd, input int n, input logic [7:0] wd);
    rx_q.delete();
    cs_b_o <= 1'b0;
    #160 xbyte(a);
    xbyte({rd, 7'h00});
    repeat (n) xbyte(rd ? 8'h00 : wd);
    #160 cs_b_o <= 1'b1;
    // released line must not keep showing the last bit
    mosi_o <= ~mosi_o;
    #480;
  endtask
endmodule // serial_host_model

// ===== verilog/optical_sample_fifo_ctrl.sv
// sample queue with serial register access, watermark flag and timestamp insertion
//
// Notes on behaviour
// - each item is 24 bits, top five bits hold the type code.
// - optical values sit left-justified in the 19 bits below the type code.
// - almost-full flag sets when stored items reach 128 minus the watermark.
// - almost-full flag drives the interrupt pin when its enable bit is set.
// - reading the status register clears the almost-full flag.
// - full queue overwrites the oldest item or drops the new one, per setting.
// - with assert-style low, almost-full re-raises on every new sample while it persists.
// - with assert-style high, almost-full raises only on a fresh entry into the condition.
// - with clear-on-data-read low, only a status read clears the two flags.
// - with clear-on-data-read high, a data read or status read clears the flags.
// - flush empties the queue and zeroes both indices, count and lost tally.
// - the flush bit clears itself once the flush is done.
// - with timestamps on, a timestamp item is pushed once every 8 sample periods (items marked last).
// - with timestamps off, no counter items enter the queue.
// - each sample period yields one item per active slot per active channel.
// - the queue holds 128 items with 7-bit indices that wrap.
// - lost tally counts overflow losses, saturates at 0x7f, clears on a pop.
// - items are read as three-byte bursts; the pop comes as the third byte starts shifting out.
// - reading an empty queue returns an item tagged invalid.
`timescale 1ns/1ps
`include "osf_defs.svh"
module optical_sample_fifo_ctrl #(
  parameter int unsigned DEPTH    = `OSF_DEPTH,
  parameter int unsigned TS_EVERY = `OSF_TS_EVERY
) (
  // clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_b_i,
  // serial register interface
  input  wire logic            sclk_i,
  input  wire logic            cs_b_i,
  input  wire logic            mosi_i,
  output logic                 miso_o,
  output logic                 miso_oe_o,
  // items from the conversion process
  input  wire logic            sample_valid_i,
  input  wire osf_pkg::item_s  sample_item_i,
  input  wire logic            sample_last_i,
  output logic                 sample_ready_o,
  // status pins
  output logic                 int_b_o,
  output logic                 power_down_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(TS_EVERY);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [TW-1:0] TS_LAST = TW'(TS_EVERY - 1);

  if (DEPTH != (1 << AW) || AW < 3 || AW > 7 || TS_EVERY < 2 || TS_EVERY != (1 << TW)) begin : g_bad_param
    $error("queue depth must be a power of two up to 128, timestamp spacing a power of two");
  end

  // reset release through two flip-flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // pins sampled on the system clock
  logic s_sclk;
  logic s_cs_b;
  logic s_mosi;
  logic s_sel;
  logic sclk_prev_q;
  // select is synced active high so the cleared stages read as deselected after reset
  osf_sync #(.WIDTH(3)) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .async_i   ({sclk_i, !cs_b_i, mosi_i}),
    .sync_o    ({s_sclk, s_sel, s_mosi})
  );
  assign s_cs_b = !s_sel;

  // registers and queue state
  logic [23:0]         mem [DEPTH];
  logic [AW-1:0]       wr_q;
  logic [AW-1:0]       rd_q;
  logic [AW:0]         count_q;
  logic [6:0]          lost_q;
  logic [6:0]          wmark_q;
  logic [7:0]          behav_q;
  logic [7:0]          int_en_q;
  logic                flush_q;
  logic                soft_q;
  logic                pdown_q;
  logic                afull_q;
  logic                newsmp_q;
  logic                afull_prev_q;
  logic                int_q;
  logic [TW-1:0]       per_q;
  logic [18:0]         tstamp_q;
  logic                ts_due_q;

  // serial engine state
  osf_pkg::spi_phase_e phase_q;
  logic [2:0]          bit_q;
  logic [7:0]          sh_q;
  logic [7:0]          tx_q;
  logic [7:0]          addr_q;
  logic [7:0]          held_addr_q;
  logic                rd_cmd_q;
  logic [1:0]          byte_idx_q;
  logic [15:0]         hold_q;
  logic                item_ok_q;

  // buffer between conversion process and queue
  osf_pkg::sample_s    buf_out;
  logic                buf_valid;
  logic                buf_ready;
  osf_skid_buffer #(.WIDTH($bits(osf_pkg::sample_s))) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .in_data_i   ({sample_item_i, sample_last_i}),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_out)
  );

  // push path; a due timestamp stalls the buffer for one cycle
  logic        clr;
  logic        take;
  logic        push;
  logic [23:0] push_word;
  logic        pop;
  logic        eff_full;
  logic        lost;
  logic        wr_en;
  logic        ovwr;
  logic        afull_cond;
  logic        period_end;
  assign clr        = flush_q || soft_q;
  assign ovwr       = behav_q[`OSF_BIT_OVWR];
  assign buf_ready  = !ts_due_q && !clr;
  assign take       = buf_valid && buf_ready;
  assign period_end = take && buf_out.last;
  assign push       = take || (ts_due_q && !clr);
  assign push_word  = ts_due_q ? {`OSF_TAG_TSTAMP, tstamp_q} : {buf_out.item.tag, buf_out.item.value};
  assign eff_full   = (count_q == FULL_CNT) && !pop;
  assign lost       = push && eff_full;
  assign wr_en      = push && (!eff_full || ovwr);
  assign afull_cond = count_q >= (FULL_CNT - (AW+1)'(wmark_q));

  // serial edges and byte events
  logic       rise;
  logic       fall;
  logic [7:0] sh_d;
  logic       byte_done;
  logic       wr_byte;
  logic       rd_load;
  logic       commit;
  logic [7:0] addr_next;
  logic [7:0] ld_addr;
  logic [7:0] ld_byte;
  logic [23:0] head_word;
  assign rise      = s_sclk && !sclk_prev_q && !s_cs_b;
  assign fall      = !s_sclk && sclk_prev_q && !s_cs_b;
  assign sh_d      = {sh_q[6:0], s_mosi};
  assign byte_done = rise && (bit_q == 3'h7);
  assign wr_byte   = byte_done && (phase_q == osf_pkg::PH_DATA) && !rd_cmd_q;
  assign rd_load   = byte_done && (((phase_q == osf_pkg::PH_CMD) && sh_d[`OSF_BIT_CMD_READ]) ||
                                   ((phase_q == osf_pkg::PH_DATA) && rd_cmd_q));
  // side effects wait until the loaded byte really starts shifting out
  assign commit    = rise && (bit_q == 3'h0) && (phase_q == osf_pkg::PH_DATA) && rd_cmd_q;
  assign addr_next = (addr_q == `OSF_ADDR_DATA) ? addr_q : addr_q + 8'h01;
  assign ld_addr   = (phase_q == osf_pkg::PH_CMD) ? addr_q : addr_next;
  assign head_word = (count_q == '0) ? {`OSF_TAG_INVALID, 19'h00000} : mem[rd_q];

  logic status_rd;
  logic data_rd;
  logic flag_clr;
  assign status_rd = commit && (held_addr_q == `OSF_ADDR_STATUS);
  assign data_rd   = commit && (held_addr_q == `OSF_ADDR_DATA);
  assign flag_clr  = status_rd || (data_rd && behav_q[`OSF_BIT_STATCLR]);
  assign pop       = data_rd && (byte_idx_q == 2'h2) && item_ok_q && !clr;

  always_comb begin
    ld_byte = 8'h00;
    unique case (ld_addr)
      `OSF_ADDR_STATUS: ld_byte = {afull_q, newsmp_q, 6'h00};
      `OSF_ADDR_INT_EN: ld_byte = int_en_q;
      `OSF_ADDR_WR_IDX: ld_byte = 8'(wr_q);
      `OSF_ADDR_RD_IDX: ld_byte = 8'(rd_q);
      `OSF_ADDR_LOST:   ld_byte = {1'b0, lost_q};
      `OSF_ADDR_COUNT:  ld_byte = 8'(count_q);
      `OSF_ADDR_DATA:   ld_byte = (byte_idx_q == 2'h0) ? head_word[23:16] :
                                  (byte_idx_q == 2'h1) ? hold_q[15:8] : hold_q[7:0];
      `OSF_ADDR_WMARK:  ld_byte = {1'b0, wmark_q};
      `OSF_ADDR_BEHAV:  ld_byte = {behav_q[7:5], flush_q, behav_q[3:0]};
      `OSF_ADDR_SYSCTL: ld_byte = {6'h00, pdown_q, soft_q};
      default:          ld_byte = 8'h00;
    endcase
  end

  // serial framing, shifting and address walk
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      phase_q     <= osf_pkg::PH_ADDR;
      bit_q       <= 3'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      addr_q      <= 8'h00;
      held_addr_q <= 8'h00;
      rd_cmd_q    <= 1'b0;
    end else begin
      sclk_prev_q <= s_sclk;
      if (s_cs_b) begin
        phase_q <= osf_pkg::PH_ADDR;
        bit_q   <= 3'h0;
      end else if (rise) begin
        sh_q  <= sh_d;
        bit_q <= bit_q + 3'h1;
        if (byte_done) begin
          unique case (phase_q)
            osf_pkg::PH_ADDR: begin
              addr_q  <= sh_d;
              phase_q <= osf_pkg::PH_CMD;
            end
            osf_pkg::PH_CMD: begin
              rd_cmd_q <= sh_d[`OSF_BIT_CMD_READ];
              phase_q  <= osf_pkg::PH_DATA;
            end
            osf_pkg::PH_DATA: addr_q <= addr_next;
            default: phase_q <= osf_pkg::PH_ADDR;
          endcase
        end
      end else if (fall && bit_q != 3'h0) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      if (rd_load) begin
        tx_q        <= ld_byte;
        held_addr_q <= ld_addr;
      end
    end
  end
  assign miso_o    = tx_q[7];
  assign miso_oe_o = !s_cs_b && rd_cmd_q && (phase_q == osf_pkg::PH_DATA);

  // data port byte position within an item
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      byte_idx_q <= 2'h0;
      hold_q     <= 16'h0000;
      item_ok_q  <= 1'b0;
    end else begin
      if (rd_load && ld_addr == `OSF_ADDR_DATA && byte_idx_q == 2'h0) begin
        hold_q    <= head_word[15:0];
        item_ok_q <= (count_q != '0);
      end
      if (s_cs_b || clr) begin
        byte_idx_q <= 2'h0;
      end else if (data_rd) begin
        byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h0 : byte_idx_q + 2'h1;
      end
    end
  end

  // software-written configuration; flush and soft reset clear themselves
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wmark_q  <= `OSF_RST_WMARK;
      behav_q  <= `OSF_RST_BEHAV;
      int_en_q <= `OSF_RST_INT_EN;
      flush_q  <= 1'b0;
      soft_q   <= 1'b0;
      pdown_q  <= 1'b0;
    end else begin
      flush_q <= wr_byte && (addr_q == `OSF_ADDR_BEHAV) && sh_d[`OSF_BIT_FLUSH];
      soft_q  <= wr_byte && (addr_q == `OSF_ADDR_SYSCTL) && sh_d[`OSF_BIT_SOFTRST];
      if (soft_q) begin
        wmark_q  <= `OSF_RST_WMARK;
        behav_q  <= `OSF_RST_BEHAV;
        int_en_q <= `OSF_RST_INT_EN;
        pdown_q  <= 1'b0;
      end else if (wr_byte) begin
        unique case (addr_q)
          `OSF_ADDR_WMARK:  wmark_q  <= sh_d[6:0];
          `OSF_ADDR_BEHAV:  behav_q  <= {2'h0, sh_d[5], 1'b0, sh_d[3:1], 1'b0};
          `OSF_ADDR_INT_EN: int_en_q <= {sh_d[7:6], 6'h00};
          `OSF_ADDR_SYSCTL: pdown_q  <= sh_d[`OSF_BIT_PDOWN];
          default: ;
        endcase
      end
    end
  end
  assign power_down_o = pdown_q;

  // queue indices, count and lost tally
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      lost_q  <= 7'h00;
    end else if (clr) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      lost_q  <= 7'h00;
    end else if (wr_byte && addr_q == `OSF_ADDR_RD_IDX) begin
      rd_q    <= sh_d[AW-1:0];
      count_q <= {1'b0, wr_q - sh_d[AW-1:0]};
    end else begin
      if (wr_en) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop || (lost && ovwr)) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, wr_en && !lost} - {{AW{1'b0}}, pop};
      if (pop) begin
        lost_q <= 7'h00;
      end else if (lost && lost_q != `OSF_LOST_MAX) begin
        lost_q <= lost_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (wr_en && !clr) begin
      mem[wr_q] <= push_word;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      per_q    <= '0;
      tstamp_q <= 19'h00000;
      ts_due_q <= 1'b0;
    end else if (clr) begin
      per_q    <= '0;
      ts_due_q <= 1'b0;
    end else begin
      if (ts_due_q) begin
        ts_due_q <= 1'b0;
      end
      if (period_end) begin
        tstamp_q <= tstamp_q + 19'h00001;
        per_q    <= per_q + 1'b1;
        if (per_q == TS_LAST && behav_q[`OSF_BIT_TS_EN]) begin
          ts_due_q <= 1'b1;
        end
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  logic afull_set;
  // entry into the condition sets either type
  assign afull_set = behav_q[`OSF_BIT_AFTYPE] ? (afull_cond && !afull_prev_q) :
                                                (afull_cond && (take || !afull_prev_q));
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      afull_q      <= 1'b0;
      newsmp_q     <= 1'b0;
      afull_prev_q <= 1'b0;
      int_q        <= 1'b0;
    end else begin
      afull_prev_q <= afull_cond;
      if (afull_set) begin
        afull_q <= 1'b1;
      end else if (flag_clr || soft_q) begin
        afull_q <= 1'b0;
      end
      if (period_end) begin
        newsmp_q <= 1'b1;
      end else if (flag_clr || soft_q) begin
        newsmp_q <= 1'b0;
      end
      int_q <= (afull_q && int_en_q[`OSF_BIT_AFULL]) || (newsmp_q && int_en_q[`OSF_BIT_NEWSMP]);
    end
  end
  assign int_b_o = !int_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  a_wr_index_wrap: assert property (wr_en && !clr && !(wr_byte && addr_q == `OSF_ADDR_RD_IDX)
    |=> wr_q == $past(wr_q) + 1'b1) else $error("write index did not advance");
  a_flush_zeroes: assert property (flush_q |=> wr_q == '0 && rd_q == '0 && count_q == '0 && lost_q == 7'h00)
    else $error("flush left queue state");
  a_flush_selfclr: assert property (flush_q && !(wr_byte && addr_q == `OSF_ADDR_BEHAV) |=> !flush_q)
    else $error("flush bit stuck");
  a_drop_keeps_queue: assert property (lost && !ovwr && !clr |=> wr_q == $past(wr_q) && count_q == FULL_CNT)
    else $error("dropped item changed queue");
  a_lost_saturates: assert property (lost_q == `OSF_LOST_MAX && !pop && !clr |=> lost_q == `OSF_LOST_MAX)
    else $error("lost tally wrapped");
  a_afull_sets: assert property (afull_set |=> afull_q) else $error("almost-full not set");
  a_int_follows: assert property (afull_q && int_en_q[`OSF_BIT_AFULL] |=> !int_b_o)
    else $error("interrupt pin not asserted");
  a_status_clears: assert property (status_rd && !afull_set |=> !afull_q) else $error("status read kept flag");
  a_no_tstamp_off: assert property (push && !behav_q[`OSF_BIT_TS_EN] && !$past(behav_q[`OSF_BIT_TS_EN])
    |-> push_word[23:19] == buf_out.item.tag) else $error("timestamp pushed while off");
  a_pop_third_byte: assert property (pop |-> byte_idx_q == 2'h2 ##1 byte_idx_q == 2'h0)
    else $error("pop outside third byte");
  a_empty_invalid: assert property (rd_load && ld_addr == `OSF_ADDR_DATA && byte_idx_q == 2'h0 && count_q == '0
    |=> tx_q[7:3] == `OSF_TAG_INVALID) else $error("empty read not tagged invalid");
endmodule // optical_sample_fifo_ctrl

// ===== verilog/osf_defs.svh
// register offsets, field positions, reset values and counts of the sample queue
`ifndef OSF_DEFS_SVH
`define OSF_DEFS_SVH

`define OSF_ADDR_STATUS   8'h00
`define OSF_ADDR_INT_EN   8'h03
`define OSF_ADDR_WR_IDX   8'h04
`define OSF_ADDR_RD_IDX   8'h05
`define OSF_ADDR_LOST     8'h06
`define OSF_ADDR_COUNT    8'h07
`define OSF_ADDR_DATA     8'h08
`define OSF_ADDR_WMARK    8'h09
`define OSF_ADDR_BEHAV    8'h0a
`define OSF_ADDR_SYSCTL   8'h0d

`define OSF_BIT_AFULL     7
`define OSF_BIT_NEWSMP    6
`define OSF_BIT_TS_EN     5
`define OSF_BIT_FLUSH     4
`define OSF_BIT_STATCLR   3
`define OSF_BIT_AFTYPE    2
`define OSF_BIT_OVWR      1
`define OSF_BIT_PDOWN     1
`define OSF_BIT_SOFTRST   0
`define OSF_BIT_CMD_READ  7

`define OSF_RST_WMARK     7'h00
`define OSF_RST_BEHAV     8'h00
`define OSF_RST_INT_EN    8'h00
`define OSF_LOST_MAX      7'h7f
`define OSF_TAG_INVALID   5'h1e
`define OSF_TAG_TSTAMP    5'h1f

`define OSF_DEPTH         128
`define OSF_TS_EVERY      8
`define OSF_BYTES_ITEM    3

`endif

// ===== verilog/osf_pkg.sv
// types shared by the sample queue files
package osf_pkg;
  typedef struct packed {
    logic [4:0]  tag;
    logic [18:0] value;
  } item_s;

  typedef struct packed {
    item_s item;
    logic  last;
  } sample_s;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10
  } spi_phase_e;
endpackage

// ===== verilog/osf_skid_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module osf_skid_buffer #(
  parameter int unsigned WIDTH = 25
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot_q [2];
  logic             head_q;
  logic [1:0]       fill_q;
  logic             put;
  logic             get;

  assign in_ready_o  = (fill_q != 2'h2);
  assign out_valid_o = (fill_q != 2'h0);
  assign out_data_o  = slot_q[head_q];
  assign put         = in_valid_i && in_ready_o;
  assign get         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill_q <= 2'h0;
      head_q <= 1'b0;
    end else begin
      fill_q <= fill_q + {1'b0, put} - {1'b0, get};
      if (get) begin
        head_q <= ~head_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (put) begin
      slot_q[head_q ^ fill_q[0]] <= in_data_i;
    end
  end
endmodule // osf_skid_buffer

// ===== verilog/osf_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module osf_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // osf_sync
